// file: hdl/iss_ctl_if.sv
// Interface carrying the decoded transaction phases and the bank's style between sequencer and pin stage.
`timescale 1ns/10ps
interface iss_ctl_if;
  import iss_pkg::*;
  logic       sel_on;
  logic       strobe_on;
  logic       write_dir;
  logic [2:0] style;
  logic [1:0] lanes;

  modport seq (output sel_on, output strobe_on, output write_dir, output style,
               output lanes);
  modport pins (input sel_on, input strobe_on, input write_dir, input style,
                input lanes);
endinterface

// file: hdl/iss_pin_stage.sv
// Pin stage: maps sequencer phases onto the style-specific active-low pins.
`timescale 1ns/10ps
module iss_pin_stage
  import iss_pkg::*;
(
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Sequencer phases.
  iss_ctl_if.pins   ctl,
  // Peripheral pins.
  output logic [ISS_BANKS-1:0] periph_select_n,
  output logic [1:0]           pcmcia_select_n,
  output logic                 periph_read_strobe_n,
  output logic                 periph_write_strobe_n,
  input  wire logic [ISS_BANK_W-1:0] bank
);

  function automatic logic is_pcmcia(input logic [2:0] s);
    return (s == ISS_TYPE_PCMCIA_IO) || (s == ISS_TYPE_PCMCIA_MEM);
  endfunction

  // Pins are registered so they change together on one edge, never glitching.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      periph_select_n       <= '1;
      pcmcia_select_n       <= 2'h3;
      periph_read_strobe_n  <= 1'h1;
      periph_write_strobe_n <= 1'h1;
    end else begin
      // Even bit 0, odd bit 1.
      pcmcia_select_n <= (ctl.sel_on && is_pcmcia(ctl.style)) ? ~ctl.lanes : 2'h3;
      periph_select_n <= '1;
      if (ctl.sel_on && !is_pcmcia(ctl.style)) begin
        periph_select_n[bank] <= 1'h0;
      end
      if (ctl.style == ISS_TYPE_M_STYLE) begin
        periph_read_strobe_n  <= ~ctl.strobe_on;
        periph_write_strobe_n <= ~(ctl.sel_on && ctl.write_dir);
      end else begin
        periph_read_strobe_n  <= ~(ctl.strobe_on && !ctl.write_dir);
        periph_write_strobe_n <= ~(ctl.strobe_on && ctl.write_dir);
      end
    end
  end

  strobe_excl_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctl.style != ISS_TYPE_M_STYLE |=> !(!periph_read_strobe_n && !periph_write_strobe_n))
    else $error("read and write strobes both asserted");

endmodule

// file: hdl/iss_pkg.sv
// Package of constants and types for the I/O port strobe sequencer.
package iss_pkg;

  // ==========================================================================
  // Signalling styles, taken from a bank's timing-type field.
  localparam logic [2:0] ISS_TYPE_PCMCIA_MEM = 3'h0;
  localparam logic [2:0] ISS_TYPE_PCMCIA_IO  = 3'h1;
  localparam logic [2:0] ISS_TYPE_M_STYLE    = 3'h2;
  localparam logic [2:0] ISS_TYPE_I_STYLE    = 3'h3;

  // ==========================================================================
  // Field widths and counts.
  localparam int         ISS_BANKS      = 8;
  localparam int         ISS_BANK_W     = 3;
  localparam int         ISS_TYPE_W     = 3;
  localparam int         ISS_REPEAT_W   = 4;
  localparam int         ISS_WAIT_W     = 4;
  localparam logic [3:0] ISS_COUNT_ZERO = 4'h0;
  localparam logic [3:0] ISS_COUNT_ONE  = 4'h1;

  // ==========================================================================
  // Sequencer states, one-hot.
  typedef enum logic [5:0] {
    ISS_IDLE   = 6'h01,
    ISS_START  = 6'h02,
    ISS_SELECT = 6'h04,
    ISS_DATUM  = 6'h08,
    ISS_RELEASE= 6'h10,
    ISS_FINAL  = 6'h20
  } iss_state_e;

endpackage

// file: hdl/iss_sequencer.sv
// Top of the I/O port strobe sequencer: transaction state machine and pins.
`timescale 1ns/10ps
module iss_sequencer
  import iss_pkg::*;
(
  // Clock and reset.
  input  wire logic                         ref_clk,
  input  wire logic                         sys_rst,
  // Request from the bus interface, same clock.
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  wire logic                         req_write,
  input  wire logic [ISS_BANK_W-1:0]        req_bank,
  input  wire logic [1:0]                   req_lanes,
  input  wire logic [15:0]                  req_wdata,
  output logic [15:0]                       rd_data,
  output logic                              rd_data_valid,
  // Per-bank configuration.
  input  wire logic [ISS_BANKS*ISS_TYPE_W-1:0]   bank_timing_type,
  input  wire logic [ISS_BANKS*ISS_REPEAT_W-1:0] start_repeat_count,
  input  wire logic [ISS_BANKS*ISS_WAIT_W-1:0]   read_datum_wait_count,
  // System bus pins.
  output logic                              addr_latch_en_n,
  output logic                              xfer_frame_n,
  output logic                              sys_read_dir_n,
  output logic                              sys_write_dir_n,
  output logic                              datum_valid_n,
  // Peripheral pins.
  output logic [ISS_BANKS-1:0]              periph_select_n,
  output logic [1:0]                        pcmcia_select_n,
  output logic                              periph_read_strobe_n,
  output logic                              periph_write_strobe_n,
  input  wire logic [15:0]                  periph_data_in,
  output logic [15:0]                       periph_data_out,
  output logic                              periph_data_oe
);

  iss_ctl_if  ctl ();
  iss_state_e state;
  iss_state_e next_state;
  logic [ISS_BANK_W-1:0]   bank;
  logic                    write;
  logic [1:0]              lanes;
  logic [ISS_TYPE_W-1:0]   style;
  logic [ISS_REPEAT_W-1:0] repeat_left;
  logic [ISS_WAIT_W-1:0]   wait_left;
  logic [15:0]             data_sync1;
  logic [15:0]             data_sync2;
  logic                    take;

  // Pick one bank's field out of a packed per-bank vector.
  function automatic logic [3:0] field4(input logic [ISS_BANKS*ISS_WAIT_W-1:0] v,
                                        input logic [ISS_BANK_W-1:0] b);
    return v[b*ISS_WAIT_W +: ISS_WAIT_W];
  endfunction

  // A new request is taken when idle or in the final clock of the last one.
  // Back-to-back start.
  assign req_ready = (state == ISS_IDLE) || (state == ISS_FINAL);
  assign take      = req_valid && req_ready;

  // ==========================================================================
  // Transaction state machine.
  always_comb begin
    next_state = state;
    case (state)
      ISS_IDLE:    if (take) next_state = ISS_START;
      ISS_START:   if (repeat_left == ISS_COUNT_ZERO) next_state = ISS_SELECT;
      ISS_SELECT:  next_state = ISS_DATUM;
      ISS_DATUM:   if (wait_left == ISS_COUNT_ZERO) next_state = ISS_RELEASE;
      ISS_RELEASE: next_state = ISS_FINAL;
      ISS_FINAL:   next_state = take ? ISS_START : ISS_IDLE;
      default:     next_state = ISS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ISS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Request capture; fields are held all transaction so pins stay stable.
  // Style per bank.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bank            <= '0;
      write           <= 1'h0;
      lanes           <= 2'h0;
      style           <= ISS_TYPE_I_STYLE;
      periph_data_out <= 16'h0000;
    end else if (take) begin
      bank            <= req_bank;
      write           <= req_write;
      lanes           <= req_lanes;
      style           <= bank_timing_type[req_bank*ISS_TYPE_W +: ISS_TYPE_W];
      periph_data_out <= req_wdata;
    end
  end

  // Wait counters load at the start and count down in their phases.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      repeat_left <= ISS_COUNT_ZERO;
      wait_left   <= ISS_COUNT_ZERO;
    end else if (take) begin
      repeat_left <= field4(start_repeat_count, req_bank);
      wait_left   <= field4(read_datum_wait_count, req_bank);
    end else begin
      if (state == ISS_START && repeat_left != ISS_COUNT_ZERO) begin
        repeat_left <= repeat_left - ISS_COUNT_ONE;
      end
      if (state == ISS_DATUM && wait_left != ISS_COUNT_ZERO) begin
        wait_left <= wait_left - ISS_COUNT_ONE;
      end
    end
  end

  // ==========================================================================
  // System bus pins, registered from the next state so they align with the pins.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_latch_en_n <= 1'h1;
      xfer_frame_n    <= 1'h1;
      sys_read_dir_n  <= 1'h1;
      sys_write_dir_n <= 1'h1;
      datum_valid_n   <= 1'h1;
    end else begin
      addr_latch_en_n <= ~take;
      xfer_frame_n    <= ~take;
      if (take) begin
        // Direction level stays until the next opposite transaction.
        sys_read_dir_n  <= req_write;
        sys_write_dir_n <= ~req_write;
      end
      // Datum valid in the last datum clock.
      // Looks one clock ahead, so the pin falls together with the strobe when no wait is set.
      datum_valid_n <= ~((next_state == ISS_DATUM) && ((state == ISS_DATUM) ?
                         (wait_left == ISS_COUNT_ONE) : (wait_left == ISS_COUNT_ZERO)));
    end
  end

  // The pins lag the state by one edge, so phases are driven from next_state.
  // Select only after start.
  assign ctl.sel_on    = (next_state == ISS_SELECT) || (next_state == ISS_DATUM)
                         || (next_state == ISS_RELEASE);
  assign ctl.strobe_on = (next_state == ISS_DATUM);
  assign ctl.write_dir = write;
  assign ctl.style     = style;
  assign ctl.lanes     = lanes;

  iss_pin_stage u_pins (
    .ref_clk               (ref_clk),
    .sys_rst               (sys_rst),
    .ctl                   (ctl),
    .periph_select_n       (periph_select_n),
    .pcmcia_select_n       (pcmcia_select_n),
    .periph_read_strobe_n  (periph_read_strobe_n),
    .periph_write_strobe_n (periph_write_strobe_n),
    .bank                  (bank)
  );

  // ==========================================================================
  // Read data: the pins are asynchronous to us, so two flops before use.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_sync1 <= 16'h0000;
      data_sync2 <= 16'h0000;
    end else begin
      data_sync1 <= periph_data_in;
      data_sync2 <= data_sync1;
    end
  end

  // Sample the synchronised bus in the clock datum-valid is low.
  // Read sample.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data       <= 16'h0000;
      rd_data_valid <= 1'h0;
    end else begin
      rd_data_valid <= 1'h0;
      if (!datum_valid_n && !write) begin
        rd_data       <= data_sync2;
        rd_data_valid <= 1'h1;
      end
    end
  end

  // Write data is driven from select through release.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      periph_data_oe <= 1'h0;
    end else begin
      periph_data_oe <= ctl.sel_on && write;
    end
  end

  // ==========================================================================
  // Checks.
  first_clock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !addr_latch_en_n |-> !xfer_frame_n && (sys_read_dir_n != sys_write_dir_n))
    else $error("first clock lacks frame or direction");

  first_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !addr_latch_en_n |-> &periph_select_n && pcmcia_select_n == 2'h3
      && periph_read_strobe_n && periph_write_strobe_n)
    else $error("select or strobe active in first clock");

  select_second_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!addr_latch_en_n && repeat_left == ISS_COUNT_ZERO) |=>
      xfer_frame_n && (!(&periph_select_n) || pcmcia_select_n != 2'h3))
    else $error("select not asserted in second clock");

  read_strobe_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!addr_latch_en_n && !write && style == ISS_TYPE_I_STYLE
      && repeat_left == ISS_COUNT_ZERO && wait_left == ISS_COUNT_ZERO)
      |=> ##1 !periph_read_strobe_n && !datum_valid_n ##1 periph_read_strobe_n)
    else $error("read strobe timing wrong");

  write_strobe_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!addr_latch_en_n && write && style == ISS_TYPE_I_STYLE
      && repeat_left == ISS_COUNT_ZERO && wait_left == ISS_COUNT_ZERO)
      |=> ##1 !periph_write_strobe_n && !datum_valid_n ##1 periph_write_strobe_n)
    else $error("write strobe timing wrong");

  select_drop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == ISS_RELEASE) |=> &periph_select_n && pcmcia_select_n == 2'h3)
    else $error("select not released after strobe");

  lane_pair_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == ISS_SELECT && style == ISS_TYPE_PCMCIA_IO) |-> pcmcia_select_n == ~lanes)
    else $error("pcmcia pair does not match lanes");

  repeat_delay_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!addr_latch_en_n && repeat_left == ISS_COUNT_ONE) |=> &periph_select_n
      && pcmcia_select_n == 2'h3)
    else $error("start repeat did not delay select");

  wait_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == ISS_DATUM && wait_left != ISS_COUNT_ZERO) |-> datum_valid_n)
    else $error("datum valid before wait expired");

  cover_read_c:   cover property (@(posedge ref_clk) !datum_valid_n && !write);
  cover_write_c:  cover property (@(posedge ref_clk) !datum_valid_n && write);
  cover_b2b_c:    cover property (@(posedge ref_clk) state == ISS_FINAL && take);
  cover_pcmcia_c: cover property (@(posedge ref_clk) pcmcia_select_n == 2'h0);

endmodule

// file: test/iss_periph_model.sv
// Behavioural model of an I/O peripheral on the far side of the sequencer.
`timescale 1ns/10ps
module iss_periph_model
  import iss_pkg::*;
(
  // Pins from the sequencer.
  input  wire logic [ISS_BANKS-1:0] periph_select_n,
  input  wire logic [1:0]           pcmcia_select_n,
  input  wire logic                 periph_read_strobe_n,
  input  wire logic                 periph_write_strobe_n,
  input  wire logic [15:0]          periph_data_out,
  input  wire logic                 periph_data_oe,
  input  wire logic                 sys_write_dir_n,
  // Data handed back and the last word written.
  input  wire logic [15:0]          read_value,
  output logic      [15:0]          periph_data_in,
  output logic      [15:0]          captured
);
  logic        selected;
  logic [15:0] drv = 16'h0000;

  // Any single select or either half of the pair counts as selected.
  assign selected = !(&periph_select_n) || !(&pcmcia_select_n);
  assign periph_data_in = drv;

  // Nothing holds the bus when unselected, so show a changing pattern there.
  always @(selected or periph_data_oe or read_value) begin
    if (selected && !periph_data_oe) begin
      drv = read_value;
    end else begin
      drv = ~drv;
    end
  end

  // Strobe edge capture.
  // Write data is taken on the rising strobe edge while still selected.
  // The board takes its write direction from the system write level.
  always @(posedge periph_read_strobe_n or posedge periph_write_strobe_n) begin
    if (selected && periph_data_oe && !sys_write_dir_n) begin
      captured <= periph_data_out;
    end
  end
endmodule

// file: test/tb.sv
// Self-checking testbench for the I/O port strobe sequencer.
`timescale 1ns/10ps
module tb;
  import iss_pkg::*;
  // ==========================================================================
  // Stimulus and observed signals.
  logic        ref_clk               = 1'b0;
  logic        sys_rst               = 1'b1;
  logic        req_valid             = 1'b0;
  logic        req_write             = 1'b0;
  logic [2:0]  req_bank              = 3'h0;
  logic [1:0]  req_lanes             = 2'h3;
  logic [15:0] req_wdata             = 16'h0000;
  logic [23:0] bank_timing_type      = 24'h000000;
  logic [31:0] start_repeat_count    = 32'h00000000;
  logic [31:0] read_datum_wait_count = 32'h00000000;
  logic [15:0] read_value            = 16'h0000;
  logic        req_ready, rd_data_valid, addr_latch_en_n, xfer_frame_n, datum_valid_n;
  logic        sys_read_dir_n, sys_write_dir_n, periph_data_oe;
  logic        periph_read_strobe_n, periph_write_strobe_n;
  logic [7:0]  periph_select_n;
  logic [1:0]  pcmcia_select_n;
  logic [15:0] rd_data, periph_data_in, periph_data_out, captured;
  int          fails = 0, n_compared = 0, cycles = 0;

  // Twenty megahertz clock.
  always #25 ref_clk = ~ref_clk;

  iss_sequencer u_iss_sequencer (
    .ref_clk, .sys_rst, .req_valid, .req_ready, .req_write, .req_bank, .req_lanes,
    .req_wdata, .rd_data, .rd_data_valid, .bank_timing_type, .start_repeat_count,
    .read_datum_wait_count, .addr_latch_en_n, .xfer_frame_n, .sys_read_dir_n,
    .sys_write_dir_n, .datum_valid_n, .periph_select_n, .pcmcia_select_n,
    .periph_read_strobe_n, .periph_write_strobe_n, .periph_data_in,
    .periph_data_out, .periph_data_oe
  );
  iss_periph_model u_iss_periph_model (
    .periph_select_n, .pcmcia_select_n, .periph_read_strobe_n, .periph_write_strobe_n,
    .periph_data_out, .periph_data_oe, .sys_write_dir_n, .read_value, .periph_data_in,
    .captured
  );

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One single-datum transfer; selects are judged in every clock of it, the other pins in every clock but the start-repeat ones.
  // Single datum, one halfword at most.
  task automatic xfer(input logic [2:0] typ, input logic wr, input logic [2:0] bnk,
                      input logic [1:0] ln, input int r, input int w);
    logic       pc, ms, win, stb;
    logic [9:0] want;
    logic [9:0] seen;
    logic [9:0] sw;
    pc = (typ == ISS_TYPE_PCMCIA_MEM) || (typ == ISS_TYPE_PCMCIA_IO);
    ms = (typ == ISS_TYPE_M_STYLE);
    @(posedge ref_clk);
    bank_timing_type[3*bnk +: 3] <= typ;
    start_repeat_count[4*bnk +: 4] <= r[3:0];
    read_datum_wait_count[4*bnk +: 4] <= w[3:0];
    req_wdata <= {8'hA5, r[0], w[3:0], bnk};
    read_value <= {8'h3C, 5'h1F, bnk};
    req_valid <= 1'b1;
    req_write <= wr;
    req_bank <= bnk;
    req_lanes <= ln;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    for (int k = 1; k <= 5 + r + w; k++) begin
      @(negedge ref_clk);
      win = (k >= 2 + r) && (k <= 4 + r + w);
      stb = (k >= 3 + r) && (k <= 3 + r + w);
      want = {k != 1, k != 1, wr, !wr, !(stb && (ms || !wr)),
              ms ? !(win && wr) : !(stb && wr), k != 3 + r + w, k == 5 + r + w,
              !wr && (k == 4 + r + w), wr && win};
      seen = {addr_latch_en_n, xfer_frame_n, sys_read_dir_n, sys_write_dir_n,
              periph_read_strobe_n, periph_write_strobe_n, datum_valid_n, req_ready,
              rd_data_valid, periph_data_oe};
      sw = {(win && !pc) ? ~(8'h01 << bnk) : 8'hFF, (win && pc) ? ~ln : 2'h3};
      if (k == 1 || k >= 2 + r) begin
        chk("frame", 16'(seen[9:8]), 16'(want[9:8]));
        chk("direction", 16'(seen[7:6]), 16'(want[7:6]));
        chk("strobes", 16'(seen[5:4]), 16'(want[5:4]));
        chk("datum and ready", 16'(seen[3:1]), 16'(want[3:1]));
        chk("write enable", 16'(seen[0]), 16'(want[0]));
      end
      chk("selects", 16'(periph_select_n), 16'(sw[9:2]));
      chk("pair", 16'(pcmcia_select_n), 16'(sw[1:0]));
    end
    if (wr) begin
      chk("written data", captured, {8'hA5, r[0], w[3:0], bnk});
    end else if (w >= 2) begin
      chk("read data", rd_data, {8'h3C, 5'h1F, bnk});
    end
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_i_style;
    xfer(ISS_TYPE_I_STYLE, 1'b0, 3'h3, 2'h3, 0, 0);
    xfer(ISS_TYPE_I_STYLE, 1'b1, 3'h5, 2'h3, 0, 0);
    xfer(ISS_TYPE_I_STYLE, 1'b0, 3'h5, 2'h3, 0, 2);
    $display("test i_style done");
  endtask

  task automatic t_m_style;
    xfer(ISS_TYPE_M_STYLE, 1'b1, 3'h1, 2'h3, 0, 0);
    xfer(ISS_TYPE_M_STYLE, 1'b0, 3'h0, 2'h3, 0, 2);
    $display("test m_style done");
  endtask

  task automatic t_pcmcia;
    for (int l = 1; l <= 3; l++) begin
      xfer(ISS_TYPE_PCMCIA_IO, 1'b0, 3'h2, l[1:0], 0, 0);
    end
    xfer(ISS_TYPE_PCMCIA_MEM, 1'b1, 3'h4, 2'h1, 0, 0);
    xfer(ISS_TYPE_PCMCIA_IO, 1'b1, 3'h4, 2'h2, 1, 2);
    $display("test pcmcia done");
  endtask

  task automatic t_waits;
    xfer(ISS_TYPE_I_STYLE, 1'b0, 3'h6, 2'h3, 1, 0);
    xfer(ISS_TYPE_M_STYLE, 1'b1, 3'h7, 2'h3, 2, 1);
    xfer(3'h5, 1'b1, 3'h5, 2'h3, 0, 15);
    xfer(3'h7, 1'b0, 3'h6, 2'h3, 15, 15);
    $display("test waits done");
  endtask

  // Cuts a hung run short; every transfer here ends within forty clocks.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      end_sim();
    end
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_i_style();
    t_m_style();
    t_pcmcia();
    t_waits();
    end_sim();
  end
endmodule
